// [shared/stack_cpu_pkg.sv]
// Constants, types and opcode encodings shared by the stack processor core and its ALU.
// Assumes a single 100 MHz system clock and a Wishbone-style 16-bit bus with 8-bit granularity.
package stack_cpu_pkg;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int PC_W   = 15;
    localparam int OP_W   = 4;
    localparam int SLOTS  = 4;
    localparam int BYTE_W = 8;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [PC_W-1:0]   waddr_t;
    typedef logic [OP_W-1:0]   opcode_t;
    typedef logic [1:0]        slot_t;
    typedef logic [1:0]        lane_t;

    // Opcode encodings
    localparam opcode_t OP_NOP            = 4'h0;
    localparam opcode_t OP_IMMEDIATE_PUSH = 4'h1;
    localparam opcode_t OP_WORD_LOAD      = 4'h2;
    localparam opcode_t OP_WORD_STORE     = 4'h3;
    localparam opcode_t OP_BYTE_LOAD      = 4'h4;
    localparam opcode_t OP_BYTE_STORE     = 4'h5;
    localparam opcode_t OP_ADD            = 4'h6;
    localparam opcode_t OP_AND            = 4'h7;
    localparam opcode_t OP_XOR            = 4'h8;

    // Byte lane selects, bit 1 = data bits 15:8, bit 0 = data bits 7:0
    localparam lane_t SEL_NONE = 2'h0;
    localparam lane_t SEL_LOW  = 2'h1;
    localparam lane_t SEL_HIGH = 2'h2;
    localparam lane_t SEL_WORD = 2'h3;

    // Reset values and counter steps
    localparam waddr_t PC_RESET    = 15'h0000;
    localparam waddr_t PC_STEP     = 15'h0001;
    localparam word_t  STACK_RESET = 16'h0000;
    localparam word_t  IR_RESET    = 16'h0000;
    localparam slot_t  SLOT_FIRST  = 2'h0;
    localparam slot_t  SLOT_LAST   = 2'h3;
    localparam slot_t  SLOT_STEP   = 2'h1;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        SEQ_RESET,
        SEQ_FETCH,
        SEQ_EXEC
    } seq_state_t;

endpackage

// [hdl/stack_alu.sv]
// Combinational ALU of the stack processor: identity, sum, AND and XOR of second and top.
// Assumes the caller supplies the opcode of the slot being executed.
`timescale 1ns/1ps

module stack_alu (
    input  wire logic                  sys_clk,
    input  stack_cpu_pkg::opcode_t     op,
    input  stack_cpu_pkg::word_t       second,
    input  stack_cpu_pkg::word_t       top,
    output stack_cpu_pkg::word_t       result
);
    import stack_cpu_pkg::*;

    // Clock is unused; kept so the core sees a uniform leaf interface
    logic unused_clk;
    assign unused_clk = sys_clk;

    always_comb begin
        unique case (op)
            OP_ADD:  result = second + top;
            OP_AND:  result = second & top;
            OP_XOR:  result = second ^ top;
            // NOP and every other code pass the top cell through
            default: result = top;
        endcase
    end

endmodule

// [hdl/stack_cpu_core.sv]
// Core of a tiny 16-bit stack processor: stack, instruction slots, program counter, sequencer.
// Assumes memory and peripherals answer on a Wishbone-style bus in the sys_clk domain,
// so ack_i and dat_i are sampled without synchronisers.
`timescale 1ns/1ps

// How it works
// - top cell is every effective address
// - sixteen-bit byte addresses, no extension
// - words little-endian on even boundaries
// - word accesses ignore address bit zero
// - three cells; top gives addresses, results
// - only immediate push pushes the stack
// - pop copies third into second, third kept
// - ALU: identity, sum, AND, XOR
// - four opcode slots, high nibble first
// - slots run in order before refetch
// - remaining NOPs trigger immediate refetch
// - fifteen-bit word program counter
// - counter points at next literal or word
// - sequencer tracks slot, reset and fetch
// - each cycle: fetch, advance or hold
// - one cycle per instruction without waits
// - byte and word loads and stores
// - low acknowledge in an open cycle freezes all state
// - tags classify fetch, literal, data
// - cycle and strobe always equal, single
// - reset lasts one extra cycle, then fetch
module stack_cpu_core (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  ack_i,
    input  stack_cpu_pkg::word_t       dat_i,
    output logic                       cyc_o,
    output logic                       stb_o,
    output logic                       we_o,
    output stack_cpu_pkg::waddr_t      adr_o,
    output stack_cpu_pkg::lane_t       sel_o,
    output stack_cpu_pkg::word_t       dat_o,
    output logic                       program_space_tag,
    output logic                       data_space_tag
);
    import stack_cpu_pkg::*;

    // Opcode held in a given slot of an instruction word
    function automatic opcode_t slot_op(input word_t w, input slot_t s);
        opcode_t op;
        op = OP_NOP;
        unique case (s)
            2'h0: op = w[15:12];
            2'h1: op = w[11:8];
            2'h2: op = w[7:4];
            2'h3: op = w[3:0];
        endcase
        return op;
    endfunction

    // True when every slot from the given one onward holds a NOP
    function automatic logic rest_nop(input word_t w, input int unsigned from);
        logic all_nop;
        all_nop = 1'b1;
        for (int i = 0; i < SLOTS; i++) begin
            if (i >= from && w[WORD_W-1-i*OP_W -: OP_W] != OP_NOP) begin
                all_nop = 1'b0;
            end
        end
        return all_nop;
    endfunction

    // Sequencer state
    seq_state_t state_q;
    seq_state_t state_d;
    slot_t      slot_q;
    slot_t      slot_d;
    word_t      ir_q;
    word_t      ir_d;

    // Program counter
    waddr_t     pc_q;
    waddr_t     pc_d;

    // Parameter stack
    word_t      top_q;
    word_t      top_d;
    word_t      second_q;
    word_t      second_d;
    word_t      third_q;
    word_t      third_d;

    // Registered bus request
    logic       cyc_q;
    logic       cyc_d;
    logic       we_q;
    logic       we_d;
    waddr_t     adr_q;
    waddr_t     adr_d;
    lane_t      sel_q;
    lane_t      sel_d;
    word_t      wdat_q;
    word_t      wdat_d;
    logic       ptag_q;
    logic       ptag_d;
    logic       dtag_q;
    logic       dtag_d;

    // Shared decode
    logic       go;
    logic       exec_step;
    logic       fetch_done;
    logic       last_slot;
    opcode_t    exec_op;
    opcode_t    next_op;
    word_t      alu_res;
    word_t      byte_in;

    assign go = !cyc_q || ack_i;

    assign exec_op    = (state_q == SEQ_EXEC) ? slot_op(ir_q, slot_q) : OP_NOP;
    assign exec_step  = (state_q == SEQ_EXEC) && go;
    assign fetch_done = (state_q == SEQ_FETCH) && cyc_q && ack_i;

    assign last_slot = (slot_q == SLOT_LAST) || rest_nop(ir_q, int'(slot_q) + 1);

    assign byte_in = top_q[0] ? {BYTE_ZERO, dat_i[15:8]} : {BYTE_ZERO, dat_i[7:0]};

    stack_alu u_alu (
        .sys_clk (sys_clk),
        .op      (exec_op),
        .second  (second_q),
        .top     (top_q),
        .result  (alu_res)
    );

    always_comb begin
        state_d = state_q;
        slot_d  = slot_q;
        ir_d    = ir_q;
        unique case (state_q)
            SEQ_RESET: begin
                state_d = SEQ_FETCH;
                slot_d  = SLOT_FIRST;
            end
            SEQ_FETCH: begin
                if (fetch_done) begin
                    ir_d   = dat_i;
                    slot_d = SLOT_FIRST;
                    if (rest_nop(dat_i, 0)) begin
                        state_d = SEQ_FETCH;
                    end else begin
                        state_d = SEQ_EXEC;
                    end
                end
            end
            SEQ_EXEC: begin
                if (exec_step) begin
                    if (last_slot) begin
                        state_d = SEQ_FETCH;
                        slot_d  = SLOT_FIRST;
                    end else begin
                        slot_d  = slot_q + SLOT_STEP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= SEQ_RESET;
            slot_q  <= SLOT_FIRST;
            ir_q    <= IR_RESET;
        end else begin
            state_q <= state_d;
            slot_q  <= slot_d;
            ir_q    <= ir_d;
        end
    end

    always_comb begin
        pc_d = pc_q;
        if (fetch_done || (exec_step && exec_op == OP_IMMEDIATE_PUSH)) begin
            pc_d = pc_q + PC_STEP;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_q <= PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_comb begin
        top_d    = top_q;
        second_d = second_q;
        third_d  = third_q;
        if (exec_step) begin
            unique case (exec_op)
                OP_IMMEDIATE_PUSH: begin
                    third_d  = second_q;
                    second_d = top_q;
                    top_d    = dat_i;
                end
                OP_WORD_LOAD: begin
                    top_d = dat_i;
                end
                OP_BYTE_LOAD: begin
                    top_d = byte_in;
                end
                // Stores consume address and datum, so two pops land third in both cells
                OP_WORD_STORE,
                OP_BYTE_STORE: begin
                    top_d    = third_q;
                    second_d = third_q;
                end
                OP_ADD,
                OP_AND,
                OP_XOR: begin
                    top_d    = alu_res;
                    second_d = third_q;
                end
                default: begin
                    top_d = top_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            top_q    <= STACK_RESET;
            second_q <= STACK_RESET;
            third_q  <= STACK_RESET;
        end else begin
            top_q    <= top_d;
            second_q <= second_d;
            third_q  <= third_d;
        end
    end

    // The request for the next cycle is built from next-state values so that
    // the bus pins can come straight from flip-flops without losing a cycle.
    assign next_op = (state_d == SEQ_EXEC) ? slot_op(ir_d, slot_d) : OP_NOP;

    always_comb begin
        cyc_d  = 1'b0;
        we_d   = 1'b0;
        adr_d  = adr_q;
        sel_d  = SEL_NONE;
        wdat_d = wdat_q;
        ptag_d = 1'b0;
        dtag_d = 1'b0;
        if (state_d == SEQ_FETCH) begin
            cyc_d  = 1'b1;
            adr_d  = pc_d;
            sel_d  = SEL_WORD;
            ptag_d = 1'b1;
        end else if (state_d == SEQ_EXEC) begin
            unique case (next_op)
                OP_IMMEDIATE_PUSH: begin
                    cyc_d  = 1'b1;
                    adr_d  = pc_d;
                    sel_d  = SEL_WORD;
                    ptag_d = 1'b1;
                    dtag_d = 1'b1;
                end
                OP_WORD_LOAD: begin
                    cyc_d  = 1'b1;
                    adr_d  = top_d[ADDR_W-1:1];
                    sel_d  = SEL_WORD;
                    dtag_d = 1'b1;
                end
                OP_BYTE_LOAD: begin
                    cyc_d  = 1'b1;
                    adr_d  = top_d[ADDR_W-1:1];
                    sel_d  = top_d[0] ? SEL_HIGH : SEL_LOW;
                    dtag_d = 1'b1;
                end
                OP_WORD_STORE: begin
                    cyc_d  = 1'b1;
                    we_d   = 1'b1;
                    adr_d  = top_d[ADDR_W-1:1];
                    sel_d  = SEL_WORD;
                    wdat_d = second_d;
                    dtag_d = 1'b1;
                end
                // Byte is copied to both lanes; the select tells which one counts
                OP_BYTE_STORE: begin
                    cyc_d  = 1'b1;
                    we_d   = 1'b1;
                    adr_d  = top_d[ADDR_W-1:1];
                    sel_d  = top_d[0] ? SEL_HIGH : SEL_LOW;
                    wdat_d = {second_d[BYTE_W-1:0], second_d[BYTE_W-1:0]};
                    dtag_d = 1'b1;
                end
                // Stack-only opcodes release the bus
                default: begin
                    cyc_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cyc_q  <= 1'b0;
            we_q   <= 1'b0;
            adr_q  <= PC_RESET;
            sel_q  <= SEL_NONE;
            wdat_q <= STACK_RESET;
            ptag_q <= 1'b0;
            dtag_q <= 1'b0;
        end else begin
            cyc_q  <= cyc_d;
            we_q   <= we_d;
            adr_q  <= adr_d;
            sel_q  <= sel_d;
            wdat_q <= wdat_d;
            ptag_q <= ptag_d;
            dtag_q <= dtag_d;
        end
    end

    assign cyc_o             = cyc_q;
    assign stb_o             = cyc_q;
    assign we_o              = we_q;
    assign adr_o             = adr_q;
    assign sel_o             = sel_q;
    assign dat_o             = wdat_q;
    assign program_space_tag = ptag_q;
    assign data_space_tag    = dtag_q;

endmodule

// [tb/stack_cpu_monitor.sv]
// Checker for the bus port of the stack core: strobe, holding, tags and fetch order.
// Assumes it is bound to stack_cpu_core and sees only that module's ports.
`timescale 1ns/1ps

module stack_cpu_monitor (
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   ack_i,
    input stack_cpu_pkg::word_t        dat_i,
    input wire logic                   cyc_o,
    input wire logic                   stb_o,
    input wire logic                   we_o,
    input stack_cpu_pkg::waddr_t       adr_o,
    input stack_cpu_pkg::lane_t        sel_o,
    input stack_cpu_pkg::word_t        dat_o,
    input wire logic                   program_space_tag,
    input wire logic                   data_space_tag
);
    import stack_cpu_pkg::*;

    // Word address the next program request must carry
    waddr_t nxt_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nxt_q <= PC_RESET;
        end else if (cyc_o && ack_i && program_space_tag) begin
            nxt_q <= adr_o + PC_STEP;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_cyc_stb_equal: assert property (cyc_o == stb_o)
        else $error("cycle and strobe differ");
    a_hold_on_wait: assert property (cyc_o && !ack_i |=>
        $stable({cyc_o, we_o, adr_o, sel_o, dat_o, program_space_tag, data_space_tag}))
        else $error("request changed while waiting");
    a_tags_busy: assert property (cyc_o == (program_space_tag || data_space_tag))
        else $error("tags do not match bus activity");
    a_write_data_tag: assert property (cyc_o && we_o |-> data_space_tag && !program_space_tag)
        else $error("write carries program tag");
    a_fetch_whole_word: assert property (cyc_o && program_space_tag |-> sel_o == SEL_WORD && !we_o)
        else $error("program fetch not a word read");
    a_prog_order: assert property (cyc_o && program_space_tag |-> adr_o == nxt_q)
        else $error("program address out of sequence");
    a_byte_lane_dup: assert property (cyc_o && we_o && sel_o != SEL_WORD |->
        sel_o != SEL_NONE && dat_o[15:8] == dat_o[7:0])
        else $error("byte store lanes wrong");
    a_reset_fetch: assert property ($fell(rst) |-> !cyc_o ##1
        (cyc_o && adr_o == PC_RESET && program_space_tag && !data_space_tag))
        else $error("no fetch after extra reset cycle");
    a_nop_refetch: assert property (cyc_o && ack_i && program_space_tag &&
        !data_space_tag && dat_i == 16'h0000 |=> cyc_o && program_space_tag && !data_space_tag)
        else $error("all-idle word not skipped");
    a_alu_one_cycle: assert property (cyc_o && ack_i && program_space_tag &&
        !data_space_tag && dat_i == 16'h6000 |=> !cyc_o ##1 (cyc_o && program_space_tag))
        else $error("stack-only slot not one idle cycle");

    c_write: cover property (cyc_o && we_o && ack_i);
    c_wait: cover property (cyc_o && !ack_i ##1 cyc_o && ack_i);
    c_reset: cover property ($fell(rst));
endmodule

// [tb/bus_memory_model.sv]
// Memory on the far side of the core's bus: word array, byte lanes, set wait states.
// Assumes the bench sets wait_n and loads the program into mem while the core is held in reset.
`timescale 1ns/1ps

module bus_memory_model (
    input wire logic                   sys_clk,
    input wire logic                   cyc_o,
    input wire logic                   stb_o,
    input wire logic                   we_o,
    input stack_cpu_pkg::waddr_t       adr_o,
    input stack_cpu_pkg::lane_t        sel_o,
    input stack_cpu_pkg::word_t        dat_o,
    output logic                       ack_i,
    output stack_cpu_pkg::word_t       dat_i
);
    import stack_cpu_pkg::*;

    word_t mem [0:32767];
    int    wait_n;
    int    cnt;

    initial begin
        ack_i = 1'b0;
        dat_i = 16'h0000;
        wait_n = 0;
        cnt = 0;
    end

    // transfer ends on each rising clock edge that sees acknowledge high
    always @(negedge sys_clk) begin
        ack_i <= cyc_o && stb_o && (cnt >= wait_n);
        // Read data is valid only with acknowledge; otherwise it toggles
        if (cyc_o && stb_o && !we_o && cnt >= wait_n) begin
            dat_i <= mem[adr_o];
        end else begin
            dat_i <= ~dat_i;
        end
    end

    always @(posedge sys_clk) begin
        if (cyc_o && stb_o && ack_i) begin
            cnt <= 0;
            if (we_o && sel_o[0]) begin
                mem[adr_o][7:0] <= dat_o[7:0];
            end
            if (we_o && sel_o[1]) begin
                mem[adr_o][15:8] <= dat_o[15:8];
            end
        end else if (cyc_o && stb_o) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the stack core: runs small programs and inspects memory.
// Assumes the memory model answers the bus and the monitor is bound to the core.
`timescale 1ns/1ps

module tb_top;
    import stack_cpu_pkg::*;

    logic   sys_clk;
    logic   rst;
    logic   ack_i;
    logic   cyc_o;
    logic   stb_o;
    logic   we_o;
    logic   program_space_tag;
    logic   data_space_tag;
    word_t  dat_i;
    word_t  dat_o;
    waddr_t adr_o;
    lane_t  sel_o;
    int     error_cnt;
    int     n_compared;

    stack_cpu_core dut_u (.sys_clk(sys_clk), .rst(rst), .ack_i(ack_i), .dat_i(dat_i),
        .cyc_o(cyc_o), .stb_o(stb_o), .we_o(we_o), .adr_o(adr_o), .sel_o(sel_o),
        .dat_o(dat_o), .program_space_tag(program_space_tag), .data_space_tag(data_space_tag));

    bus_memory_model mem_u (.sys_clk(sys_clk), .cyc_o(cyc_o), .stb_o(stb_o), .we_o(we_o),
        .adr_o(adr_o), .sel_o(sel_o), .dat_o(dat_o), .ack_i(ack_i), .dat_i(dat_i));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check_eq(input string what, input word_t seen, input word_t exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reset may land in mid-program; memory is reloaded while it is held
    task automatic load_prog(input word_t prog [], input int wait_cycles);
        @(negedge sys_clk);
        rst = 1'b1;
        for (int i = 0; i < 32768; i++) begin
            mem_u.mem[i] = 16'h0000;
        end
        foreach (prog[i]) begin
            mem_u.mem[i] = prog[i];
        end
        mem_u.wait_n = wait_cycles;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        // No request before the extra reset edge
        check_eq("cyc at release", {15'h0000, cyc_o}, 16'h0000);
        @(posedge sys_clk);
        #1;
        // Fetch of word zero follows
        check_eq("first fetch",
            {cyc_o, program_space_tag, data_space_tag, adr_o[12:0]}, 16'hc000);
    endtask

    task automatic test_push_alu_store();
        word_t prog [];
        prog = '{16'h1116, 16'h1111, 16'h2222, 16'h5555, 16'h0000, 16'h3000, 16'h1300,
            16'h0100, 16'h6000, 16'h1300, 16'h0200};
        load_prog(prog, 0);
        repeat (60) @(negedge sys_clk);
        // Store address is the sum held in top
        check_eq("store at sum", mem_u.mem[15'h3bbb], 16'h1111);
        // Third cell refills second on pop
        check_eq("pop refill", mem_u.mem[15'h0080], 16'h1111);
        check_eq("second sum", mem_u.mem[15'h0100], 16'h2222);
    endtask

    task automatic test_bytes_waits();
        word_t prog [];
        prog = '{16'h1211, 16'h0201, 16'h0ff0, 16'h0300, 16'h7815, 16'h0301, 16'h1413,
            16'h0101, 16'h0200};
        load_prog(prog, 2);
        mem_u.mem[15'h0100] = 16'ha5c3;
        mem_u.mem[15'h0080] = 16'h5a77;
        repeat (150) @(negedge sys_clk);
        // Odd pointer byte store lands in the high lane
        check_eq("byte store", mem_u.mem[15'h0180], 16'hc300);
        // Odd pointer byte load takes the high lane and zero-extends
        check_eq("byte load", mem_u.mem[15'h0100], 16'h005a);
        check_eq("load no write", mem_u.mem[15'h0080], 16'h5a77);
    endtask

    // Even pointers use the low lane; the loaded byte feeds an XOR whose sum would differ
    task automatic test_low_lanes();
        word_t prog [];
        prog = '{16'h1151, 16'h1234, 16'h0040, 16'h0060, 16'h4181, 16'h0f0f, 16'h0082,
            16'h3000};
        load_prog(prog, 1);
        mem_u.mem[15'h0030] = 16'hbeef;
        repeat (100) @(negedge sys_clk);
        // Even pointer byte store lands in the low lane
        check_eq("low byte store", mem_u.mem[15'h0020], 16'h0034);
        // Zero-extended low byte XOR literal
        check_eq("xor store", mem_u.mem[15'h0041], 16'h0fe0);
        check_eq("low load no write", mem_u.mem[15'h0030], 16'hbeef);
    endtask

    initial begin
        rst = 1'b1;
        error_cnt = 0;
        n_compared = 0;
        test_push_alu_store();
        test_bytes_waits();
        test_low_lanes();
        complete_run();
    end

    // All three programs finish in a few hundred cycles
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule

bind stack_cpu_core stack_cpu_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .ack_i(ack_i),
    .dat_i(dat_i), .cyc_o(cyc_o), .stb_o(stb_o), .we_o(we_o), .adr_o(adr_o), .sel_o(sel_o),
    .dat_o(dat_o), .program_space_tag(program_space_tag), .data_space_tag(data_space_tag));
